/* shared/vpwlc_pkg.sv */
// Package for the link control byte block: bit layout, reset values,
// divider table and hold times.
// Assumes a 100 MHz system clock.
package vpwlc_pkg;

    // Control byte layout
    localparam int VPWLC_ACK_BIT = 7;
    localparam int VPWLC_MULTI_BIT = 6;
    localparam int VPWLC_QUIET_BIT = 5;
    localparam int VPWLC_PDOWN_BIT = 4;
    localparam int VPWLC_FAST_BIT = 3;
    localparam int VPWLC_DSEL_HI = 2;
    localparam int VPWLC_DSEL_LO = 0;
    localparam logic [7:0] VPWLC_CTRL_RESET = 8'h00;

    // Divider: forced value after reset, then table indexed by the selects
    localparam logic [4:0] VPWLC_DIV_RESET = 5'h10;
    // Entries 4 bits each, select 000 in the low nibble
    localparam logic [31:0] VPWLC_DIV_LUT = 32'h1248_5a6c;

    // Hold times and exchange bit count
    localparam int VPWLC_CLK_PERIOD_PS = 10000;
    localparam int VPWLC_QUIET_HOLD_NS = 6000;
    localparam int VPWLC_WAKE_HOLD_NS = 2000;
    localparam logic [9:0] VPWLC_QUIET_HOLD_CYC =
        10'((VPWLC_QUIET_HOLD_NS * 1000 + VPWLC_CLK_PERIOD_PS - 1) / VPWLC_CLK_PERIOD_PS);
    localparam logic [9:0] VPWLC_WAKE_HOLD_CYC =
        10'((VPWLC_WAKE_HOLD_NS * 1000 + VPWLC_CLK_PERIOD_PS - 1) / VPWLC_CLK_PERIOD_PS);
    localparam logic [3:0] VPWLC_XCHG_BITS = 4'h8;

    // Serial exchange phases
    typedef enum logic [1:0] {
        VPWLC_X_IDLE = 2'b00,
        VPWLC_X_LOW = 2'b01,
        VPWLC_X_HIGH = 2'b10
    } vpwlc_xstate_t;

endpackage

/* rtl/vpwlc_control_reg.sv */
// Link control byte of a byte-level VPW interface, with its serial
// status/control exchange, clock divider and response sequencing.
// Assumes the state machine and symbol codec sit outside and report
// their events as one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R1: Eight-bit write-only control byte; upper four flags set-only, all clear on reset.
// R2: Response flag requests response after end of data; cleared on success or idle.
// R3: Response flag may be set until 135 us after the final CRC byte.
// R4: Response byte captured during the CRC byte exchange when byte-ready raised.
// R5: Host sends single-byte responses with multi flag clear and long byte-ready.
// R6: Retried response byte sent only once; flag clears after first success.
// R7: Multi-byte response appends CRC after the long-form last byte.
// R8: After lost arbitration no further response bytes are sent.
// R9: Multi flag alone sends nothing; it clears at idle after the response.
// R10: Status copy of multi flag updates only after each data or CRC transfer.
// R11: Quiet flag restarts state machine, drives bus output low, raises idle.
// R12: Idle indicator held high at least 6 us, then low once bus idle.
// R13: No unsolicited transfers while waiting; resume with the next message.
// R14: Power-down gates clock after exchange; bus low, status edge, ready wake.
// R15: Power-down accepted only while idle low or in first exchange.
// R16: Premature wake without valid edge restarts, idle high at least 2 us.
// R17: Fast mode decodes at quarter durations and disables bus output.
// R18: Fast bit writable when idle low or first exchange; not after break.
// R19: Fast bit clears on break or low write while idle low.
// R20: Divider selects pick divide values 12,6,10,5,8,4,2,1.
// R21: Reset forces divide by sixteen, holds passive until first exchange.
// R22: Host rewrites identical divider selects in every later exchange.
// R23: Exchange shifts status out while capturing the control byte.
// R24: Byte-ready high at transfer end marks the last byte.
module vpwlc_control_reg
    import vpwlc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Host handshake and serial pins
    input wire logic status_req,
    input wire logic byte_ready,
    input wire logic serial_in,
    output logic serial_clk,
    output logic serial_out,
    // Status byte from the status logic
    input wire logic [7:0] status_byte,
    // Events from state machine and symbol codec
    input wire logic bus_symbol_input,
    input wire logic bus_edge,
    input wire logic valid_edge,
    input wire logic noise_pulse,
    input wire logic idle_detected,
    input wire logic bus_is_idle,
    input wire logic break_rx,
    input wire logic crc_xfer_done,
    input wire logic data_xfer_done,
    input wire logic [7:0] host_byte,
    input wire logic resp_tx_ok,
    input wire logic arb_lost,
    // Control outputs
    output logic [7:0] ctrl_byte,
    output logic status_multi,
    output logic base_tick,
    output logic clk_run,
    output logic sm_hold,
    output logic sm_restart,
    output logic idle_ind,
    output logic bus_out_enable,
    output logic xfer_block,
    output logic fast_decode,
    output logic resp_valid,
    output logic [7:0] resp_byte,
    output logic resp_last,
    output logic resp_append_crc
);

    ////////////////////////////////////////////////////////////////////////
    // Serial exchange

    vpwlc_xstate_t xs_q, xs_d;
    logic [3:0] bit_cnt_q;
    logic [7:0] tx_sh_q, rx_sh_q;
    logic stat_dly_q, sck_q, xdone_q;
    logic [4:0] div_cnt_q;
    logic tick_q;

    wire stat_rise = status_req & ~stat_dly_q;
    wire last_bit = (bit_cnt_q == VPWLC_XCHG_BITS - 4'h1);
    wire xchg_end = tick_q & (xs_q == VPWLC_X_HIGH) & last_bit;
    wire [7:0] wbyte = {rx_sh_q[6:0], serial_in};

    always_comb begin
        xs_d = xs_q;
        case (xs_q)
            VPWLC_X_IDLE: if (stat_rise) xs_d = VPWLC_X_LOW;
            VPWLC_X_LOW: if (tick_q) xs_d = VPWLC_X_HIGH;
            VPWLC_X_HIGH: if (tick_q) xs_d = last_bit ? VPWLC_X_IDLE : VPWLC_X_LOW;
            default: xs_d = VPWLC_X_IDLE;
        endcase
    end

    // Status leaves MSB first while control enters MSB first
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            xs_q <= VPWLC_X_IDLE;
            bit_cnt_q <= 4'h0;
            tx_sh_q <= 8'h00;
            rx_sh_q <= 8'h00;
            stat_dly_q <= 1'b0;
            sck_q <= 1'b0;
            xdone_q <= 1'b0;
        end else begin
            xs_q <= xs_d;
            stat_dly_q <= status_req;
            xdone_q <= xchg_end;
            if (xs_q == VPWLC_X_IDLE && stat_rise) begin
                tx_sh_q <= status_byte; // R23
                bit_cnt_q <= 4'h0;
            end else if (tick_q && xs_q == VPWLC_X_LOW) begin
                sck_q <= 1'b1;
            end else if (tick_q && xs_q == VPWLC_X_HIGH) begin
                sck_q <= 1'b0;
                rx_sh_q <= wbyte; // R23
                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock divider

    logic first_q, brk_first_q;
    logic [7:0] ctl_q;
    wire [2:0] dsel = ctl_q[VPWLC_DSEL_HI:VPWLC_DSEL_LO];
    wire [4:0] div_sel = {1'b0, VPWLC_DIV_LUT[{dsel, 2'b00} +: 4]}; // R20
    wire [4:0] div_val = first_q ? VPWLC_DIV_RESET : div_sel; // R21

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_cnt_q <= 5'h00;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_cnt_q >= div_val - 5'h01);
            div_cnt_q <= (div_cnt_q >= div_val - 5'h01) ? 5'h00 : div_cnt_q + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control byte

    logic idle_q, resp_done_q, lost_q, fast_q, multi_st_q, restart_q;
    logic [9:0] hold_q;
    logic wake_arm_q;
    logic rv_q, rl_q, rc_q;
    logic [7:0] rb_q;

    wire wr = xchg_end;
    wire wr_open = ~idle_q | first_q;
    wire ack_clr = resp_tx_ok | idle_detected; // R2
    wire multi_clr = idle_detected & resp_done_q; // R9
    wire quiet_done = idle_detected & (hold_q == 10'h000);
    wire pd_wake = ~bus_symbol_input | stat_rise | byte_ready; // R14
    wire fast_set_ok = wr & wr_open & ~(wbyte[VPWLC_FAST_BIT] & brk_first_q); // R18
    wire fast_wr_clr = wr & ~wbyte[VPWLC_FAST_BIT] & ~idle_q; // R19

    // Set from the host wins over a hardware clear in the same cycle, except break_rx clearing the fast bit
    wire ack_d = (ctl_q[VPWLC_ACK_BIT] & ~ack_clr) | (wr & wbyte[VPWLC_ACK_BIT]); // R3
    wire multi_d = (ctl_q[VPWLC_MULTI_BIT] & ~multi_clr) | (wr & wbyte[VPWLC_MULTI_BIT]);
    wire quiet_d = (ctl_q[VPWLC_QUIET_BIT] & ~quiet_done) | (wr & wbyte[VPWLC_QUIET_BIT]);
    wire pd_d = (ctl_q[VPWLC_PDOWN_BIT] & ~pd_wake) | (wr & wr_open & wbyte[VPWLC_PDOWN_BIT]);
    wire fast_d = break_rx ? 1'b0 :
        fast_set_ok ? wbyte[VPWLC_FAST_BIT] :
        fast_wr_clr ? 1'b0 : ctl_q[VPWLC_FAST_BIT];
    wire [2:0] dsel_d = wr ? wbyte[VPWLC_DSEL_HI:VPWLC_DSEL_LO] : dsel; // R22
    wire quiet_start = wr & wbyte[VPWLC_QUIET_BIT];
    wire early_wake = ctl_q[VPWLC_PDOWN_BIT] & (byte_ready | noise_pulse) & ~valid_edge;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ctl_q <= VPWLC_CTRL_RESET; // R1
            first_q <= 1'b1;
            brk_first_q <= 1'b0;
        end else begin
            ctl_q <= {ack_d, multi_d, quiet_d, pd_d, fast_d, dsel_d}; // R1 R15 R18 R19
            if (wr) first_q <= 1'b0; // R21
            if (break_rx) brk_first_q <= 1'b1;
            else if (wr) brk_first_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle indicator, quiet wait and wake handling

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hold_q <= 10'h000;
            idle_q <= 1'b1;
            restart_q <= 1'b0;
            wake_arm_q <= 1'b0;
        end else begin
            restart_q <= quiet_start | early_wake; // R11 R16
            if (quiet_start)
                hold_q <= VPWLC_QUIET_HOLD_CYC; // R12
            else if (early_wake)
                hold_q <= VPWLC_WAKE_HOLD_CYC; // R16
            else if (hold_q != 10'h000)
                hold_q <= hold_q - 10'h001;
            wake_arm_q <= early_wake;
            if (quiet_start || early_wake)
                idle_q <= 1'b1; // R11
            else if (hold_q == 10'h000 && (bus_is_idle || idle_detected))
                idle_q <= 1'b0; // R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response sequencing

    wire long_form = byte_ready; // R24
    wire resp_go = ctl_q[VPWLC_ACK_BIT] & ~lost_q & ~resp_done_q; // R6 R8 R9

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lost_q <= 1'b0;
            resp_done_q <= 1'b0;
            multi_st_q <= 1'b0;
            fast_q <= 1'b0;
            rv_q <= 1'b0;
            rb_q <= 8'h00;
            rl_q <= 1'b0;
            rc_q <= 1'b0;
        end else begin
            if (data_xfer_done || crc_xfer_done)
                multi_st_q <= ctl_q[VPWLC_MULTI_BIT]; // R10
            if (bus_edge)
                fast_q <= ctl_q[VPWLC_FAST_BIT]; // R17 R18 R19
            if (idle_detected)
                lost_q <= 1'b0;
            else if (arb_lost && ctl_q[VPWLC_ACK_BIT])
                lost_q <= 1'b1; // R8
            if (idle_detected)
                resp_done_q <= 1'b0;
            else if (resp_tx_ok && ctl_q[VPWLC_ACK_BIT])
                resp_done_q <= 1'b1; // R6
            rv_q <= resp_go & (crc_xfer_done | data_xfer_done); // R4
            if (resp_go && (crc_xfer_done || data_xfer_done)) begin
                rb_q <= host_byte; // R4
                rl_q <= long_form | ~ctl_q[VPWLC_MULTI_BIT]; // R5 R24
                rc_q <= long_form & ctl_q[VPWLC_MULTI_BIT]; // R7
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic sout_q, run_q, hold_sm_q, oe_q, blk_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sout_q <= 1'b0;
            run_q <= 1'b1;
            hold_sm_q <= 1'b1;
            oe_q <= 1'b0;
            blk_q <= 1'b0;
        end else begin
            sout_q <= (xs_d == VPWLC_X_IDLE) ? 1'b0 :
                (xs_q == VPWLC_X_IDLE) ? status_byte[7] :
                (tick_q && xs_q == VPWLC_X_HIGH) ? tx_sh_q[6] : tx_sh_q[7];
            run_q <= ~pd_d; // R14
            hold_sm_q <= first_q & ~wr; // R21
            oe_q <= ~fast_d & ~quiet_d & ~first_q; // R11 R17
            blk_q <= quiet_d; // R13
        end
    end

    assign serial_clk = sck_q;
    assign serial_out = sout_q;
    assign ctrl_byte = ctl_q;
    assign status_multi = multi_st_q;
    assign base_tick = tick_q;
    assign clk_run = run_q;
    assign sm_hold = hold_sm_q;
    assign sm_restart = restart_q;
    assign idle_ind = idle_q;
    assign bus_out_enable = oe_q;
    assign xfer_block = blk_q;
    assign fast_decode = fast_q;
    assign resp_valid = rv_q;
    assign resp_byte = rb_q;
    assign resp_last = rl_q;
    assign resp_append_crc = rc_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    ack_set_only_a: assert property ( // R2
        $fell(ctl_q[VPWLC_ACK_BIT]) |-> $past(resp_tx_ok) || $past(idle_detected))
        else $error("response flag cleared without cause");
    multi_clear_a: assert property ( // R9
        $fell(ctl_q[VPWLC_MULTI_BIT]) |-> $past(idle_detected))
        else $error("multi flag cleared outside idle");
    quiet_idle_a: assert property ( // R11
        wr && wbyte[VPWLC_QUIET_BIT] |=> idle_q && restart_q ##1 !bus_out_enable)
        else $error("quiet wait did not raise idle");
    quiet_hold_a: assert property ( // R12
        wr && wbyte[VPWLC_QUIET_BIT] |=> idle_q [*8])
        else $error("idle dropped too early");
    pd_accept_a: assert property ( // R15
        $rose(ctl_q[VPWLC_PDOWN_BIT]) |-> $past(wr_open))
        else $error("power-down taken while idle high");
    fast_oe_a: assert property ( // R17
        ctl_q[VPWLC_FAST_BIT] |-> !bus_out_enable)
        else $error("bus output on in fast mode");
    fast_break_a: assert property ( // R19
        break_rx |=> !ctl_q[VPWLC_FAST_BIT])
        else $error("fast bit survived a break");
    lost_block_a: assert property ( // R8
        lost_q |=> !resp_valid)
        else $error("response byte after lost arbitration");
    status_copy_a: assert property ( // R10
        !(data_xfer_done || crc_xfer_done) |=> $stable(status_multi))
        else $error("status copy moved without transfer");
    div_reset_a: assert property ( // R21
        first_q && tick_q && !wr |=> !tick_q [*8])
        else $error("divider not sixteen before first exchange");

    xchg_c: cover property (stat_rise ##[1:400] xdone_q);
    type3_c: cover property (resp_valid && resp_append_crc);
    wake_c: cover property (early_wake ##1 sm_restart);

endmodule

`default_nettype wire

/* tb/vpwlc_host_model.sv */
// Host model for the serial status/control exchange.
// Assumes the device drives serial_clk and samples serial_in on its fall.
`timescale 1ns/1ps
`default_nettype none
module vpwlc_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Bench side
    input wire logic start,
    input wire logic [7:0] ctrl_in,
    output logic [7:0] stat_out,
    output logic done,
    // Device pins
    output logic status_req,
    output logic serial_in,
    input wire logic serial_clk,
    input wire logic serial_out
);
    logic [7:0] shift_q;
    logic [3:0] cnt_q;
    logic sclk_q;
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        sclk_q <= serial_clk;
        done <= 1'b0;
        if (!reset_n) begin
            status_req <= 1'b0;
            serial_in <= 1'b0;
        end else if (start && !status_req) begin
            status_req <= 1'b1;
            shift_q <= ctrl_in;
            serial_in <= ctrl_in[7];
            cnt_q <= 4'h0;
        end else if (status_req) begin
            if (serial_clk && !sclk_q) begin
                stat_out <= {stat_out[6:0], serial_out};
            end
            if (!serial_clk && sclk_q) begin
                cnt_q <= cnt_q + 4'h1;
                shift_q <= {shift_q[6:0], 1'b0};
                serial_in <= shift_q[6];
                if (cnt_q == 4'h7) begin
                    // Released line shows the inverse, never a stale bit
                    status_req <= 1'b0;
                    serial_in <= ~shift_q[7];
                    done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* tb/test_vpw_link_control_register.sv */
// Testbench for the link control byte block.
// Assumes the host model for exchanges; events are driven as pulses.
`timescale 1ns/1ps
`default_nettype none
module test_vpw_link_control_register
    import vpwlc_pkg::*;
;
    logic clk = 1'b0, reset_n = 1'b0, byte_ready = 1'b0, start = 1'b0;
    logic bus_is_idle = 1'b1, bus_in = 1'b1, done, status_req, serial_in;
    logic serial_clk, serial_out, status_multi, base_tick, clk_run, sm_hold, sm_restart;
    logic idle_ind, bus_out_enable, xfer_block, fast_decode, resp_valid;
    logic resp_last, resp_append_crc, seen_v, seen_l, seen_c;
    logic [7:0] status_byte = 8'ha5, host_byte = 8'h00, ctrl_in = 8'h00;
    logic [7:0] stat_out, ctrl_byte, resp_byte, seen_b;
    logic [8:0] pls = 9'h000;
    int fails = 0, checks = 0, cyc = 0, g, n;
    int div_tab[8] = '{12, 6, 10, 5, 8, 4, 2, 1};
    ////////////////////////////////////////////////////////////////
    vpwlc_control_reg dut (.clk(clk), .reset_n(reset_n), .status_req(status_req),
        .byte_ready(byte_ready), .serial_in(serial_in), .serial_clk(serial_clk),
        .serial_out(serial_out), .status_byte(status_byte), .bus_symbol_input(bus_in),
        .bus_edge(pls[0]), .valid_edge(pls[1]), .noise_pulse(pls[2]),
        .idle_detected(pls[3]), .bus_is_idle(bus_is_idle), .break_rx(pls[4]),
        .crc_xfer_done(pls[5]), .data_xfer_done(pls[6]), .host_byte(host_byte),
        .resp_tx_ok(pls[7]), .arb_lost(pls[8]), .ctrl_byte(ctrl_byte),
        .status_multi(status_multi), .base_tick(base_tick), .clk_run(clk_run),
        .sm_hold(sm_hold), .sm_restart(sm_restart), .idle_ind(idle_ind),
        .bus_out_enable(bus_out_enable), .xfer_block(xfer_block),
        .fast_decode(fast_decode), .resp_valid(resp_valid), .resp_byte(resp_byte),
        .resp_last(resp_last), .resp_append_crc(resp_append_crc));
    vpwlc_host_model host (.clk(clk), .reset_n(reset_n), .start(start),
        .ctrl_in(ctrl_in), .stat_out(stat_out), .done(done), .status_req(status_req),
        .serial_in(serial_in), .serial_clk(serial_clk), .serial_out(serial_out));
    ////////////////////////////////////////////////////////////////
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Answer may land one or two edges after the event
    task automatic pulse(input logic [8:0] p);
        seen_v = 1'b0;
        @(posedge clk);
        #1 pls = p;
        repeat (2) begin
            @(posedge clk);
            #1 pls = 9'h000;
            if (resp_valid === 1'b1) begin
                seen_v = 1'b1;
                seen_b = resp_byte;
                seen_l = resp_last;
                seen_c = resp_append_crc;
            end
        end
    endtask
    task automatic xchg(input logic [7:0] c);
        @(posedge clk);
        #1 ctrl_in = c;
        start = 1'b1;
        @(posedge clk);
        #1 start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 2000) fails++;
        repeat (2) @(posedge clk);
        #1 chk(stat_out, status_byte);
    endtask
    task automatic tick_gap();
        n = 0;
        while (base_tick !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        g = 0;
        do begin
            @(posedge clk);
            #1 g++;
        end while (base_tick !== 1'b1 && g < 100);
    endtask
    task test_done();
        if (fails == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 8; i++) begin
            reset_n = 1'b0;
            repeat (6) @(posedge clk);
            #1 reset_n = 1'b1;
            chk({ctrl_byte[6:0], idle_ind}, 8'h01);
            chk({sm_hold, bus_out_enable}, 8'h02);
            tick_gap();
            chk(8'(g), 8'h10);
            xchg({5'h00, 3'(i)});
            chk({sm_hold, ctrl_byte}, {1'b0, 5'h00, 3'(i)});
            tick_gap();
            chk(8'(g), 8'(div_tab[i]));
        end
        xchg(8'h87);
        byte_ready = 1'b1;
        host_byte = 8'h5a;
        pulse(9'h020);
        chk({seen_v, seen_l, seen_c, seen_b}, {3'b110, 8'h5a});
        byte_ready = 1'b0;
        xchg(8'h07);
        chk(ctrl_byte[7], 1'b1);
        pulse(9'h080);
        chk(ctrl_byte[7], 1'b0);
        pulse(9'h040);
        chk(seen_v, 1'b0);
        pulse(9'h008);
        xchg(8'hc7);
        chk(status_multi, 1'b0);
        pulse(9'h040);
        chk({seen_v, seen_l, seen_c, status_multi}, 4'b1001);
        byte_ready = 1'b1;
        pulse(9'h040);
        chk({seen_v, seen_l, seen_c}, 3'b111);
        byte_ready = 1'b0;
        pulse(9'h100);
        pulse(9'h040);
        chk(seen_v, 1'b0);
        pulse(9'h008);
        chk(ctrl_byte[7:6], 2'b01);
        pulse(9'h040);
        chk(seen_v, 1'b0);
        xchg(8'h27);
        chk({idle_ind, bus_out_enable, xfer_block}, 3'b101);
        repeat (VPWLC_QUIET_HOLD_CYC - 40) @(posedge clk);
        #1 chk(idle_ind, 1'b1);
        n = 0;
        while (idle_ind !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        chk(idle_ind, 1'b0);
        pulse(9'h008);
        chk(xfer_block, 1'b0);
        xchg(8'h0f);
        chk({ctrl_byte[3], fast_decode}, 2'b10);
        pulse(9'h001);
        chk({fast_decode, bus_out_enable}, 2'b10);
        pulse(9'h010);
        chk(ctrl_byte[3], 1'b0);
        pulse(9'h001);
        chk(fast_decode, 1'b0);
        xchg(8'h1f);
        chk({ctrl_byte[4], clk_run}, 2'b10);
        chk(ctrl_byte[3], 1'b0);
        byte_ready = 1'b1;
        @(posedge clk);
        #1 chk({ctrl_byte[4], clk_run}, 2'b01);
        chk({sm_restart, idle_ind}, 2'b11);
        byte_ready = 1'b0;
        xchg(8'h17);
        chk(ctrl_byte[4], 1'b0);
        repeat (8'hd0) @(posedge clk);
        xchg(8'h17);
        chk(ctrl_byte[4], 1'b1);
        bus_in = 1'b0;
        @(posedge clk);
        #1 chk(ctrl_byte[4], 1'b0);
        bus_in = 1'b1;
        xchg(8'hc7);
        pulse(9'h080);
        pulse(9'h008);
        chk(ctrl_byte[7:6], 2'b00);
        test_done();
    end
endmodule
`default_nettype wire
